// >>> dv/aleu_apb_master.sv
// Decoder side model: APB master that loads operands and starts operations.
// Assumes the bench calls xfer after reset release, one call at a time.
`default_nettype none

module aleu_apb_master (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [aleu_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   import aleu_pkg::*;

   logic held = 1'b0;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; nx keeps psel up for a setup right behind it
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic nx, output logic [31:0] r, output logic e);
      if (!held)
      begin
         @(posedge pclk);
         psel <= 1'b1;
      end
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      penable <= 1'b0;
      psel <= nx;
      held = nx;
   endtask
endmodule

`default_nettype wire

// >>> dv/aleu_core_checker.sv
// Checker for the execute unit's APB port, bound to the core module.
// Assumes one pclk domain and presetn active low.
`default_nettype none

module aleu_core_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [aleu_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   import aleu_pkg::*;

   // Access phase still waiting for its answer
   logic acc;
   assign acc = psel && penable && !pready;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready stood longer than one cycle");

   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr without pready");

   property p_ready_in_access;
      pready |-> psel && penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("pready outside an access phase");

   property p_read_next;
      acc && !pwrite |=> pready;
   endproperty
   a_read_next: assert property (p_read_next)
      else $error("read not answered in the next cycle");

   property p_answer_bound;
      acc |-> ##[1:3] pready;
   endproperty
   a_answer_bound: assert property (p_answer_bound)
      else $error("access not answered within three cycles");

   // A write may wait behind a running operation before it is refused
   property p_unmapped;
      acc && paddr > REG_STAT |-> ##[1:3] (pready && pslverr && prdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   property p_bad_op;
      acc && pwrite && paddr == REG_CMD && pwdata[4:0] > OP_LAST |-> ##[1:3] (pready && pslverr);
   endproperty
   a_bad_op: assert property (p_bad_op)
      else $error("illegal operation code accepted");

   property p_read_clean;
      acc && !pwrite && paddr <= REG_STAT && paddr[1:0] == 2'h0
         |=> !pslverr && prdata[31:16] == 16'h0;
   endproperty
   a_read_clean: assert property (p_read_clean)
      else $error("mapped read flagged or upper bits set");

   property p_flags_byte;
      acc && !pwrite && paddr == REG_SREG |=> prdata[31:8] == 24'h0;
   endproperty
   a_flags_byte: assert property (p_flags_byte)
      else $error("flag read wider than a byte");

   property p_reset_quiet;
      $rose(presetn) |-> !pready && !pslverr;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("answer right after reset release");

   c_refused: cover property (pready && pslverr);
   c_word: cover property (acc && pwrite && paddr == REG_CMD &&
      pwdata[4:0] == OP_ADD_IMMEDIATE_WORD);
   c_jump: cover property (acc && pwrite && paddr == REG_CMD && pwdata[4:0] == OP_RELATIVE_JUMP);
endmodule

bind aleu_core aleu_core_checker u_aleu_core_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// >>> dv/aleu_tb_top.sv
// Self-checking bench: integer model of every operation against the unit.
// Assumes the APB master model in dv/ and the checker bound to the core.
`default_nettype none

module aleu_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aleu_pkg::*;

   logic pclk = 1'b0;
   logic presetn;
   logic psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   int errors = 0;
   int compares = 0;
   logic [31:0] seed = 32'hc197f13f;

   always #2.5 pclk = ~pclk;

   aleu_core u_aleu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   aleu_apb_master u_aleu_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Model result: {pair high, destination, flags}
   function automatic logic [23:0] ref_op(input int op, d, s, h, f);
      int r;
      int c;
      int w;
      logic [7:0] fl;
      fl = f[7:0];
      c = f & 1;
      r = d;
      case (op)
         0, 1:
         begin
            c = (op == 0) ? 0 : c;
            r = d + s + c;
            fl[0] = r > 255;
            fl[5] = (d % 16 + s % 16 + c) > 15;
            fl[3] = (~(d ^ s) & (d ^ r) & 128) != 0;
         end
         3, 4, 5, 6, 14:
         begin
            c = (op < 5 || op == 14) ? 0 : c;
            s = (op == 14) ? d : s;
            d = (op == 14) ? 0 : d;
            r = d - s - c;
            fl[0] = r < 0;
            fl[5] = (d % 16 - s % 16 - c) < 0;
            fl[3] = ((d ^ s) & (d ^ r) & 128) != 0;
         end
         8, 9: r = d & s;
         10, 11, 15: r = d | s;
         12: r = d ^ s;
         16: r = d & ~s;
         20: r = 0;
         13:
         begin
            r = ~d;
            fl[0] = 1'b1;
         end
         17: r = d + 1;
         18: r = d - 1;
         21: return {h[7:0], 8'hff, fl};
         2, 7:
         begin
            w = h * 256 + d;
            r = (op == 2) ? w + s : w - s;
            fl[0] = r > 65535 || r < 0;
            fl[3] = (op == 2) ? (~w & r & 32768) != 0 : (w & ~r & 32768) != 0;
            fl[2] = r[15];
            fl[1] = r[15:0] == 16'h0;
            fl[4] = fl[2] ^ fl[3];
            return {r[15:0], fl};
         end
         default: ;
      endcase
      // Twos complement keeps its arithmetic overflow
      if (op >= 8 && op <= 20 && op != 14)
         fl[3] = (op == 17) ? r[7:0] == 8'h80 : (op == 18) ? r[7:0] == 8'h7f : 1'b0;
      fl[2] = r[7];
      fl[1] = r[7:0] == 8'h0;
      return {h[7:0], r[7:0], fl};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_err(input string nm, input logic exp, input logic got);
      chk(nm, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      u_aleu_apb_master.xfer(1'b1, a, d, 1'b0, r, e);
      chk_err("write error", 1'b0, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      u_aleu_apb_master.xfer(1'b0, a, 32'h0, 1'b0, r, e);
      chk_err("read error", 1'b0, e);
   endtask

   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (30000) @(posedge pclk);
      errors++;
      give_verdict();
   end

   initial
   begin
      logic [31:0] d, s, h, f, r;
      logic [23:0] x;
      logic e;
      int o;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of the operand and status registers
      for (int a = 4; a <= 28; a += 4)
      begin
         rd(a[7:0], r);
         chk("reset value", 32'h0, r);
      end
      // Every operation but the relative jump, boundary operands first, then random ones
      for (int k = 0; k < 8; k++)
         for (int op = 0; op <= 21; op++)
         begin
            d = (k < 2) ? 32'h7f + k : rnd();
            s = (k < 2) ? 32'h1 + 32'h7f * k : rnd();
            h = (k < 2) ? 32'hff : rnd();
            f = rnd();
            wr(REG_DEST, {24'h0, d[7:0]});
            wr(REG_SRC, {24'h0, s[7:0]});
            wr(REG_DESTH, {24'h0, h[7:0]});
            wr(REG_SREG, {24'h0, f[7:0]});
            wr(REG_CMD, {27'h0, op[4:0]});
            x = ref_op(op, d[7:0], s[7:0], h[7:0], f[7:0]);
            rd(REG_DEST, r);
            chk("dest", {24'h0, x[15:8]}, r);
            rd(REG_DESTH, r);
            chk("pair high", {24'h0, x[23:16]}, r);
            rd(REG_SREG, r);
            chk("flags", {24'h0, x[7:0]}, r);
            rd(REG_STAT, r);
            chk("cycles", (op == 2 || op == 7) ? 32'h20 : 32'h10, r);
         end
      // Relative jump with wrap at both ends and random offsets
      for (int k = 0; k < 6; k++)
      begin
         d = (k == 0) ? 32'h0 : (k == 1) ? 32'hffff : rnd();
         s = (k == 0) ? 32'hffe : (k == 1) ? 32'h0 : rnd();
         f = rnd();
         o = s[11:0];
         o = (o > 2047) ? o - 4096 : o;
         wr(REG_SREG, {24'h0, f[7:0]});
         wr(REG_PC, {16'h0, d[15:0]});
         wr(REG_JOFS, {20'h0, s[11:0]});
         wr(REG_CMD, {27'h0, OP_RELATIVE_JUMP});
         rd(REG_PC, r);
         chk("jump target", (d[15:0] + o + 1) & 32'hffff, r);
         rd(REG_SREG, r);
         chk("jump flags", {24'h0, f[7:0]}, r);
         rd(REG_STAT, r);
         chk("jump cycles", 32'h20, r);
      end
      // Refused accesses and an ignored status write leave the state alone
      wr(REG_DEST, 32'h5a);
      u_aleu_apb_master.xfer(1'b0, 8'h20, 32'h0, 1'b0, r, e);
      chk_err("unmapped error", 1'b1, e);
      chk("unmapped data", 32'h0, r);
      u_aleu_apb_master.xfer(1'b1, REG_CMD, 32'h17, 1'b0, r, e);
      chk_err("bad code error", 1'b1, e);
      u_aleu_apb_master.xfer(1'b1, REG_STAT, 32'hff, 1'b0, r, e);
      chk_err("status write error", 1'b0, e);
      rd(REG_DEST, r);
      chk("dest after refusal", 32'h5a, r);
      rd(REG_STAT, r);
      chk("status kept", 32'h20, r);
      // Write right behind a word operation, carry into the high byte
      wr(REG_DESTH, 32'h12);
      wr(REG_DEST, 32'hff);
      wr(REG_SRC, 32'h01);
      u_aleu_apb_master.xfer(1'b1, REG_CMD, {27'h0, OP_ADD_IMMEDIATE_WORD}, 1'b1, r, e);
      wr(REG_DEST, 32'h33);
      rd(REG_DESTH, r);
      chk("pair carry", 32'h13, r);
      rd(REG_DEST, r);
      chk("late write", 32'h33, r);
      give_verdict();
   end
endmodule

`default_nettype wire

// >>> src/aleu_add8.sv
// Byte adder and subtractor with carry, half-carry and overflow.
// Assumes the core holds the operands steady for the whole operation.
`default_nettype none

module aleu_add8 (
   aleu_dp_if.add8 dp
);
   import aleu_pkg::*;

   logic [DATA_W-1:0] bx;
   logic cx;
   logic [DATA_W:0] full;
   logic [4:0] low;

   // Subtraction adds the inverted operand and inverted borrow
   always_comb
   begin
      bx = dp.sub ? ~dp.b : dp.b;
      cx = dp.sub ? ~dp.cin : dp.cin;
      full = {1'b0, dp.a} + {1'b0, bx} + {{DATA_W{1'b0}}, cx};
      low = {1'b0, dp.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
   end

   // Borrow is the inverse of the carry for subtraction
   assign dp.sum = full[DATA_W-1:0];
   assign dp.c = dp.sub ? ~full[DATA_W] : full[DATA_W];
   assign dp.h = dp.sub ? ~low[4] : low[4];
   assign dp.v = (dp.a[DATA_W-1] == bx[DATA_W-1]) &&
                 (full[DATA_W-1] != dp.a[DATA_W-1]);
endmodule

`default_nettype wire

// >>> src/aleu_core.sv
// Arithmetic and logic execute unit with an APB register port.
// Assumes software loads operands, then writes an operation code to start.
`default_nettype none

module aleu_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [aleu_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import aleu_pkg::*;

   aleu_regs_t s_reg;
   aleu_regs_t s_next;
   aleu_dp_if dp ();

   // Sets zero, negative and overflow of a flag byte from a result
   function automatic logic [DATA_W-1:0] set_znv(input logic [DATA_W-1:0] f,
                                                 input logic [DATA_W-1:0] r,
                                                 input logic v);
      logic [DATA_W-1:0] o;
      o = f;
      o[FLAG_Z] = (r == BYTE_ZERO);
      o[FLAG_N] = r[DATA_W-1];
      o[FLAG_V] = v;
      return o;
   endfunction

   // True for the operations that need two execution cycles
   function automatic logic is_two_cycle(input logic [OP_W-1:0] op);
      return (op == OP_ADD_IMMEDIATE_WORD) || (op == OP_SUBTRACT_IMMEDIATE_WORD) ||
             (op == OP_RELATIVE_JUMP);
   endfunction

   // Returns one when the offset decodes to a register
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == REG_CMD) || (a == REG_DEST) || (a == REG_SRC) ||
             (a == REG_DESTH) || (a == REG_SREG) || (a == REG_PC) ||
             (a == REG_JOFS) || (a == REG_STAT);
   endfunction

   // Byte and word adders
   aleu_add8 u_add8 (
      .dp(dp.add8)
   );

   aleu_word16 u_word16 (
      .dp(dp.word)
   );

   logic [DATA_W-1:0] res8;
   logic [DATA_W-1:0] flags8;
   logic wr_dest8;
   logic [WORD_W-1:0] wres;
   logic [DATA_W-1:0] wflags;
   logic [PC_W-1:0] jump_target;
   logic access;
   logic busy;

   // Adder operand steering for the latched operation
   always_comb
   begin
      dp.a = s_reg.dest;
      dp.b = s_reg.src;
      dp.cin = 1'b0;
      dp.sub = 1'b0;
      dp.wd = {s_reg.desth, s_reg.dest};
      dp.wk = s_reg.src;
      dp.wsub = (s_reg.op == OP_SUBTRACT_IMMEDIATE_WORD);
      unique case (s_reg.op)
         OP_ADD_WITH_CARRY:
            dp.cin = s_reg.sreg[FLAG_C];
         OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE:
            dp.sub = 1'b1;
         OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_IMMEDIATE_WITH_CARRY:
         begin
            dp.sub = 1'b1;
            dp.cin = s_reg.sreg[FLAG_C];
         end
         OP_TWOS_COMPLEMENT:
         begin
            dp.a = BYTE_ZERO;
            dp.b = s_reg.dest;
            dp.sub = 1'b1;
         end
         OP_INCREMENT:
            dp.b = BYTE_ONE;
         OP_DECREMENT_REGISTER:
         begin
            dp.b = BYTE_ONE;
            dp.sub = 1'b1;
         end
         default:
            dp.cin = 1'b0;
      endcase
   end

   // Byte result and its flags
   always_comb
   begin
      res8 = dp.sum;
      flags8 = s_reg.sreg;
      wr_dest8 = 1'b1;
      unique case (s_reg.op)
         OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE,
         OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_IMMEDIATE_WITH_CARRY,
         OP_TWOS_COMPLEMENT:
         begin
            // Carry, half-carry, zero, negative and overflow from the byte adder
            flags8 = set_znv(s_reg.sreg, dp.sum, dp.v);
            flags8[FLAG_C] = dp.c;
            flags8[FLAG_H] = dp.h;
         end
         OP_AND_REGISTERS, OP_AND_IMMEDIATE:
         begin
            res8 = s_reg.dest & s_reg.src;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_OR_REGISTERS, OP_OR_IMMEDIATE, OP_SET_BITS_MASK:
         begin
            res8 = s_reg.dest | s_reg.src;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_EXCLUSIVE_OR_REGISTERS:
         begin
            res8 = s_reg.dest ^ s_reg.src;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_CLEAR_REGISTER:
         begin
            res8 = s_reg.dest ^ s_reg.dest;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_ONES_COMPLEMENT:
         begin
            res8 = BYTE_ONES - s_reg.dest;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
            flags8[FLAG_C] = 1'b1;
         end
         OP_CLEAR_BITS_MASK:
         begin
            res8 = s_reg.dest & (BYTE_ONES - s_reg.src);
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_INCREMENT, OP_DECREMENT_REGISTER:
            flags8 = set_znv(s_reg.sreg, dp.sum, dp.v);
         OP_TEST_REGISTER:
         begin
            res8 = s_reg.dest & s_reg.dest;
            flags8 = set_znv(s_reg.sreg, res8, 1'b0);
         end
         OP_SET_REGISTER_ALL_ONES:
            res8 = BYTE_ONES;
         default:
            wr_dest8 = 1'b0;
      endcase
   end

   // Word result, word flags and jump target
   always_comb
   begin
      wres = dp.wres;
      wflags = s_reg.sreg;
      wflags[FLAG_Z] = (dp.wres == {WORD_W{1'b0}});
      wflags[FLAG_N] = dp.wres[WORD_W-1];
      wflags[FLAG_V] = dp.wv;
      wflags[FLAG_C] = dp.wc;
      wflags[FLAG_S] = dp.wres[WORD_W-1] ^ dp.wv;
      jump_target = s_reg.pc + {{(PC_W-JOFS_W){s_reg.jofs[JOFS_W-1]}}, s_reg.jofs} +
                    {{(PC_W-1){1'b0}}, 1'b1};
   end

   assign access = psel && penable && !s_reg.rdy;
   assign busy = (s_reg.st != ST_IDLE);

   // Bus slave, sequencer and register updates
   always_comb
   begin
      s_next = s_reg;
      s_next.rdy = 1'b0;
      s_next.slverr = 1'b0;   // Error stands only with its ready pulse
      // Execution: one-cycle ops commit in EXEC1, word ops and jump in EXEC2
      unique case (s_reg.st)
         ST_IDLE:
            s_next.st = ST_IDLE;
         ST_EXEC1:
         begin
            if (is_two_cycle(s_reg.op))
               s_next.st = ST_EXEC2;
            else
            begin
               if (wr_dest8)
                  s_next.dest = res8;
               s_next.sreg = flags8;
               s_next.last_cyc = CYC_ONE;
               s_next.st = ST_IDLE;
            end
         end
         ST_EXEC2:
         begin
            if (s_reg.op == OP_RELATIVE_JUMP)
               s_next.pc = jump_target;
            else
            begin
               s_next.dest = wres[DATA_W-1:0];
               s_next.desth = wres[WORD_W-1:DATA_W];
               s_next.sreg = wflags;
            end
            s_next.last_cyc = CYC_TWO;
            s_next.st = ST_IDLE;
         end
         default:
            s_next.st = ST_IDLE;
      endcase
      // Reads answer at once; writes wait until execution has ended
      if (access && (!pwrite || !busy))
      begin
         s_next.rdy = 1'b1;
         s_next.slverr = !is_mapped(paddr);
         s_next.rdata = 32'h0000_0000;
         if (pwrite)
         begin
            unique case (paddr)
               REG_CMD:
               begin
                  if (pwdata[OP_W-1:0] <= OP_LAST)
                  begin
                     s_next.op = pwdata[OP_W-1:0];
                     s_next.st = ST_EXEC1;
                  end
                  else
                     s_next.slverr = 1'b1;   // Unknown operation code
               end
               REG_DEST:
                  s_next.dest = pwdata[DATA_W-1:0];
               REG_SRC:
                  s_next.src = pwdata[DATA_W-1:0];
               REG_DESTH:
                  s_next.desth = pwdata[DATA_W-1:0];
               REG_SREG:
                  s_next.sreg = pwdata[DATA_W-1:0];
               REG_PC:
                  s_next.pc = pwdata[PC_W-1:0];
               REG_JOFS:
                  s_next.jofs = pwdata[JOFS_W-1:0];
               default:
                  s_next.rdata = 32'h0000_0000;   // Read-only or unmapped
            endcase
         end
         else
         begin
            unique case (paddr)
               REG_CMD:
                  s_next.rdata[OP_W-1:0] = s_reg.op;
               REG_DEST:
                  s_next.rdata[DATA_W-1:0] = s_reg.dest;
               REG_SRC:
                  s_next.rdata[DATA_W-1:0] = s_reg.src;
               REG_DESTH:
                  s_next.rdata[DATA_W-1:0] = s_reg.desth;
               REG_SREG:
                  s_next.rdata[DATA_W-1:0] = s_reg.sreg;
               REG_PC:
                  s_next.rdata[PC_W-1:0] = s_reg.pc;
               REG_JOFS:
                  s_next.rdata[JOFS_W-1:0] = s_reg.jofs;
               REG_STAT:
               begin
                  s_next.rdata[STAT_BUSY] = busy;
                  s_next.rdata[STAT_CYC_LSB +: 2] = s_reg.last_cyc;
               end
               default:
                  s_next.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg.st <= ST_IDLE;
         s_reg.op <= OP_ADD;
         s_reg.dest <= BYTE_RST;
         s_reg.src <= BYTE_RST;
         s_reg.desth <= BYTE_RST;
         s_reg.sreg <= SREG_RST;
         s_reg.pc <= PC_RST;
         s_reg.jofs <= {JOFS_W{1'b0}};
         s_reg.last_cyc <= 2'h0;
         s_reg.rdy <= 1'b0;
         s_reg.slverr <= 1'b0;
         s_reg.rdata <= 32'h0000_0000;
      end
      else
         s_reg <= s_next;
   end

   // Bus outputs straight from the state register
   assign prdata = s_reg.rdata;
   assign pready = s_reg.rdy;
   assign pslverr = s_reg.slverr;
endmodule

`default_nettype wire

// >>> src/aleu_dp_if.sv
// Interface joining the core to its byte adder and word adder.
// Assumes both adders are purely combinational.
`default_nettype none

interface aleu_dp_if;
   import aleu_pkg::*;
   // Byte adder operands and results
   logic [DATA_W-1:0] a;
   logic [DATA_W-1:0] b;
   logic cin;
   logic sub;
   logic [DATA_W-1:0] sum;
   logic c;
   logic h;
   logic v;
   // Word adder operands and results
   logic [WORD_W-1:0] wd;
   logic [DATA_W-1:0] wk;
   logic wsub;
   logic [WORD_W-1:0] wres;
   logic wc;
   logic wv;

   modport core (output a, b, cin, sub, wd, wk, wsub, input sum, c, h, v, wres, wc, wv);
   modport add8 (input a, b, cin, sub, output sum, c, h, v);
   modport word (input wd, wk, wsub, output wres, wc, wv);
endinterface

`default_nettype wire

// >>> src/aleu_pkg.sv
// Package for the arithmetic and logic execute unit: register map,
// status flag layout, operation codes, state and state record types.
// Assumes one clock domain and an APB slave port with 32-bit data.
`default_nettype none

package aleu_pkg;

   // Datapath widths
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int PC_W = 16;
   localparam int JOFS_W = 12;
   localparam int OP_W = 5;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;   // Write starts an operation
   localparam logic [ADDR_W-1:0] REG_DEST = 8'h04;  // Destination, low byte of a pair
   localparam logic [ADDR_W-1:0] REG_SRC = 8'h08;   // Source register or constant
   localparam logic [ADDR_W-1:0] REG_DESTH = 8'h0c; // High byte of a register pair
   localparam logic [ADDR_W-1:0] REG_SREG = 8'h10;  // Status flags
   localparam logic [ADDR_W-1:0] REG_PC = 8'h14;    // Program counter
   localparam logic [ADDR_W-1:0] REG_JOFS = 8'h18;  // Signed jump offset
   localparam logic [ADDR_W-1:0] REG_STAT = 8'h1c;  // Busy and last cycle count

   // Status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int STAT_BUSY = 0;
   localparam int STAT_CYC_LSB = 4;

   // Reset values and fixed constants
   localparam logic [DATA_W-1:0] SREG_RST = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 16'h0000;
   localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;

   // Operation codes written to REG_CMD
   localparam logic [OP_W-1:0] OP_ADD = 5'h00;
   localparam logic [OP_W-1:0] OP_ADD_WITH_CARRY = 5'h01;
   localparam logic [OP_W-1:0] OP_ADD_IMMEDIATE_WORD = 5'h02;
   localparam logic [OP_W-1:0] OP_SUBTRACT = 5'h03;
   localparam logic [OP_W-1:0] OP_SUBTRACT_IMMEDIATE = 5'h04;
   localparam logic [OP_W-1:0] OP_SUBTRACT_WITH_CARRY = 5'h05;
   localparam logic [OP_W-1:0] OP_SUBTRACT_IMMEDIATE_WITH_CARRY = 5'h06;
   localparam logic [OP_W-1:0] OP_SUBTRACT_IMMEDIATE_WORD = 5'h07;
   localparam logic [OP_W-1:0] OP_AND_REGISTERS = 5'h08;
   localparam logic [OP_W-1:0] OP_AND_IMMEDIATE = 5'h09;
   localparam logic [OP_W-1:0] OP_OR_REGISTERS = 5'h0a;
   localparam logic [OP_W-1:0] OP_OR_IMMEDIATE = 5'h0b;
   localparam logic [OP_W-1:0] OP_EXCLUSIVE_OR_REGISTERS = 5'h0c;
   localparam logic [OP_W-1:0] OP_ONES_COMPLEMENT = 5'h0d;
   localparam logic [OP_W-1:0] OP_TWOS_COMPLEMENT = 5'h0e;
   localparam logic [OP_W-1:0] OP_SET_BITS_MASK = 5'h0f;
   localparam logic [OP_W-1:0] OP_CLEAR_BITS_MASK = 5'h10;
   localparam logic [OP_W-1:0] OP_INCREMENT = 5'h11;
   localparam logic [OP_W-1:0] OP_DECREMENT_REGISTER = 5'h12;
   localparam logic [OP_W-1:0] OP_TEST_REGISTER = 5'h13;
   localparam logic [OP_W-1:0] OP_CLEAR_REGISTER = 5'h14;
   localparam logic [OP_W-1:0] OP_SET_REGISTER_ALL_ONES = 5'h15;
   localparam logic [OP_W-1:0] OP_RELATIVE_JUMP = 5'h16;
   localparam logic [OP_W-1:0] OP_LAST = 5'h16;

   // Execution sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} aleu_state_t;

   // Whole state of the core
   typedef struct packed {
      aleu_state_t st;
      logic [OP_W-1:0] op;
      logic [DATA_W-1:0] dest;
      logic [DATA_W-1:0] src;
      logic [DATA_W-1:0] desth;
      logic [DATA_W-1:0] sreg;
      logic [PC_W-1:0] pc;
      logic [JOFS_W-1:0] jofs;
      logic [1:0] last_cyc;
      logic rdy;
      logic slverr;
      logic [31:0] rdata;
   } aleu_regs_t;

endpackage

`default_nettype wire

// >>> src/aleu_word16.sv
// Register pair adder: adds or subtracts an immediate from a 16-bit pair.
// Assumes the core samples the result in the second execution cycle.
`default_nettype none

module aleu_word16 (
   aleu_dp_if.word dp
);
   import aleu_pkg::*;

   logic [WORD_W:0] full;

   // Zero-extended immediate added or subtracted
   always_comb
   begin
      if (dp.wsub)
         full = {1'b0, dp.wd} - {{(WORD_W-DATA_W+1){1'b0}}, dp.wk};
      else
         full = {1'b0, dp.wd} + {{(WORD_W-DATA_W+1){1'b0}}, dp.wk};
   end

   // Carry or borrow out of bit 15; overflow when the sign flips wrongly
   assign dp.wres = full[WORD_W-1:0];
   assign dp.wc = full[WORD_W];
   assign dp.wv = dp.wsub ? (dp.wd[WORD_W-1] & ~full[WORD_W-1])
                          : (~dp.wd[WORD_W-1] & full[WORD_W-1]);
endmodule

`default_nettype wire
